// file: bench/cpd_top_tb.sv
// testbench of the compare pwm duty control block
// assumes cpd_top with its apb slave and cpd_defs.svh on the include path
`timescale 1ns/1ps
`include "cpd_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module cpd_top_tb;
    localparam logic [7:0] C1 = `CPD_OFF_CTRL1;
    localparam logic [7:0] C2 = `CPD_OFF_CTRL2;
    localparam logic [7:0] PRI = `CPD_OFF_PRI;
    localparam logic [7:0] SEC = `CPD_OFF_SEC;
    localparam logic [7:0] PER = `CPD_OFF_PER;
    localparam logic [7:0] CNT = `CPD_OFF_CNT;
    logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, errq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdq;
    logic cpuIdle, faultInputA, faultInputB, compareOutputPin;
    logic [4:0] timerTick;
    logic [2:0] cmpFault;
    logic [1:0] fallPhase;
    int n_errors, checks, seed, per, hi, ph, a0, a1;
    int model[6];

    cpd_top #(.CHANNEL(1)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpuIdle(cpuIdle), .timerTick(timerTick),
        .faultInputA(faultInputA), .faultInputB(faultInputB),
        .cmpFault(cmpFault), .compareOutputPin(compareOutputPin),
        .fallPhase(fallPhase));

    // ----------------------------------------
    // clock, watchdog and verdict
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // generous span: the whole sequence needs well under 10k cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_errors++;
        finish_test();
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // bus and observation helpers
    // ----------------------------------------
    // holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a hung wait
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdq = prdata;
        errq = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input int d);
        // register model: duty and period words keep the low 16 bits of what is written
        if (a >= PRI && a <= PER)
            model[a >> 2] = d & 32'h0000_ffff;
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic waitc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : waitc

    // counts high cycles; a nonzero phase other than d weighs 100
    task automatic watch(input int n, input logic [1:0] d);
        hi = 0;
        ph = 0;
        repeat (n) begin
            @(posedge sys_clk);
            hi += (compareOutputPin === 1'b1);
            if (fallPhase !== 2'h0)
                ph += (fallPhase === d) ? 1 : 100;
        end
    endtask : watch

    // counter advance across k one-cycle tick pulses on t
    task automatic cnt_delta(input int k, input logic [4:0] t);
        rd(CNT);
        a0 = rdq;
        repeat (k) begin
            @(posedge sys_clk);
            timerTick <= t;
            @(posedge sys_clk);
            timerTick <= 5'h00;
        end
        rd(CNT);
        a1 = rdq;
        a1 = (a1 - a0) & 16'hffff;
    endtask : cnt_delta

    task automatic flt(input int i, input logic v);
        case (i)
            0: cmpFault <= {2'b00, v};
            1: faultInputB <= v;
            default: faultInputA <= v;
        endcase
    endtask : flt

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 89;
        n_errors = 0;
        checks = 0;
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        {cpuIdle, timerTick, faultInputA, faultInputB, cmpFault} = '0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        // reset values, read-only bits, unmapped place
        rd(C1);
        `CHK(rdq, 32'h0000_0000)
        wr(C1, 32'hffff_ffff);
        rd(C1);
        `CHK(rdq, 32'h0000_3f8f)
        rd(8'h18);
        `CHK(errq, 1'b1)
        wr(C1, 32'h0000_0003);
        $display("test registers done");
        // time base codes: timers step on ticks, reserved never
        for (int c = 0; c < 8; c++) begin
            wr(C1, (c << 10) | 3);
            cnt_delta(5, (c < 5) ? (5'h01 << c) : 5'h1f);
            if (c == 7)
                `CHK(a1 != 0, 1'b1)
            else
                `CHK(a1, (c < 5) ? 5 : 0)
        end
        cpuIdle <= 1'b1;
        wr(C1, 32'h0000_3c03);
        cnt_delta(0, 5'h00);
        `CHK(a1, 0)
        wr(C1, 32'h0000_1c03);
        cnt_delta(0, 5'h00);
        `CHK(a1 != 0, 1'b1)
        cpuIdle <= 1'b0;
        $display("test time base done");
        // trigger hold and hardware clear at secondary match
        wr(SEC, 40);
        wr(C1, 32'h0000_1c0b);
        wr(C2, 32'h0000_0080);
        cnt_delta(0, 5'h00);
        `CHK(a0, 0)
        wr(C2, 32'h0000_00c0);
        waitc(80);
        rd(C2);
        `CHK(rdq[6], 1'b0)
        rd(CNT);
        `CHK(rdq, 32'h0000_0000)
        wr(C1, 32'h0000_1c03);
        wr(C2, 32'h0000_00c0);
        waitc(80);
        rd(C2);
        `CHK(rdq[6], 1'b1)
        wr(C2, 32'h0000_0000);
        $display("test trigger done");
        // center aligned: period, duty, sub-cycle phase
        per = 6 + ($unsigned($random(seed)) % 8);
        // mode off parks the counter at zero, else it runs to the wrap
        wr(C1, 32'h0000_1c00);
        wr(PER, per);
        wr(PRI, 1);
        wr(SEC, per - 2);
        wr(C1, 32'h0000_1c07);
        for (int d = 0; d < 4; d++) begin
            wr(C2, d << 9); // delay field used in edge, center and both dual compare modes
            waitc(3 * (per + 1));
            watch(4 * (per + 1), d[1:0]);
            if (d == 0)
                `CHK(hi, 4 * (per - 3))
            `CHK(ph, (d != 0) ? 4 : 0)
        end
        wr(C2, 32'h0000_0000);
        wr(SEC, per + 3);
        waitc(40);
        watch(40, 2'h0);
        `CHK(hi, 40)
        // zero duty and period, written while mode off parks the counter, keep the pin low
        wr(C1, 32'h0000_1c00);
        wr(PRI, 0);
        wr(SEC, 0);
        wr(PER, 0);
        wr(C1, 32'h0000_1c07);
        waitc(40);
        watch(40, 2'h0);
        `CHK(hi, 0)
        $display("test center done");
        // edge aligned bounds and fault override
        wr(C1, 32'h0000_1c06);
        waitc(20);
        watch(40, 2'h0);
        `CHK(hi, 0)
        wr(PRI, 3);
        wr(SEC, 8);
        waitc(20);
        watch(40, 2'h0);
        `CHK(hi, 40)
        wr(C1, 32'h0000_1d06);
        faultInputA <= 1'b1;
        waitc(20);
        watch(40, 2'h0);
        `CHK(hi, 40)
        wr(C1, 32'h0000_1c86);
        waitc(20);
        watch(40, 2'h0);
        `CHK(hi, 0)
        faultInputA <= 1'b0;
        waitc(20);
        watch(40, 2'h0);
        `CHK(hi, 40)
        $display("test edge done");
        // fault flags in center mode, one source at a time
        wr(PER, 9);
        wr(PRI, 1);
        wr(SEC, 5);
        wr(C1, 32'h0000_1e07);
        cmpFault <= 3'b110;
        waitc(30);
        rd(C1);
        `CHK(rdq[6], 1'b0)
        cmpFault <= 3'b000;
        for (int i = 0; i < 3; i++) begin
            wr(C1, 32'h0000_1c07);
            flt(i, 1'b1);
            waitc(30);
            rd(C1);
            `CHK(rdq[6 - i], 1'b0)
            wr(C1, 32'h0000_1c07 | (32'h0000_0200 >> i));
            waitc(30);
            rd(C1);
            `CHK(rdq[6 - i], 1'b1)
            flt(i, 1'b0);
            waitc(30);
            rd(C1);
            `CHK(rdq[6 - i], 1'b0)
        end
        $display("test fault flags done");
        // written duty and period words read back as the model holds
        for (int r = 2; r < 5; r++) begin
            rd(8'(r << 2));
            `CHK(rdq, model[r])
        end
        $display("test readback done");
        finish_test();
    end
endmodule : cpd_top_tb

// file: hdl/cpd_defs.svh
// constants of the compare pwm duty control block
// assumes inclusion by bare name from the testbench and the top
`ifndef CPD_DEFS_SVH
`define CPD_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CPD_OFF_CTRL1 8'h00
`define CPD_OFF_CTRL2 8'h04
`define CPD_OFF_PRI 8'h08
`define CPD_OFF_SEC 8'h0c
`define CPD_OFF_PER 8'h10
`define CPD_OFF_CNT 8'h14
// ----------------------------------------
// reset values
// ----------------------------------------
`define CPD_RST_CTRL 16'h0000
`define CPD_RST_WORD 16'h0000
// ----------------------------------------
// mode and time base codes
// ----------------------------------------
`define CPD_MODE_OFF 3'h0
`define CPD_MODE_SET_HI 3'h1
`define CPD_MODE_SET_LO 3'h2
`define CPD_MODE_TOGGLE 3'h3
`define CPD_MODE_DBL_ONE 3'h4
`define CPD_MODE_DBL_RUN 3'h5
`define CPD_MODE_EDGE 3'h6
`define CPD_MODE_CENTER 3'h7
`define CPD_TSEL_SYS 3'h7
`define CPD_TSEL_LAST_TMR 3'h4
`endif

// file: hdl/cpd_pkg.sv
// types of the compare pwm duty control block
// needs no include file; cpd_defs.svh is used by the top
package cpd_pkg;
    // first control word, bit 15 down to bit 0
    typedef struct packed {
        logic [1:0] unused;
        logic idleStop;
        logic [2:0] timeBaseSel;
        logic compFaultEnable;
        logic faultBEnable;
        logic faultAEnable;
        logic compFaultFlag;
        logic faultBFlag;
        logic faultAFlag;
        logic trigClearMode;
        logic [2:0] channelMode;
    } cpd_ctrl1_t;
    // second control word, bit 15 down to bit 0
    typedef struct packed {
        logic unusedA;
        logic faultLevel;
        logic [2:0] unusedB;
        logic [1:0] subcycleDelay;
        logic unusedC;
        logic trigEnable;
        logic trigger_status_bit;
        logic [5:0] unusedD;
    } cpd_ctrl2_t;
endpackage : cpd_pkg

// file: hdl/cpd_top.sv
// pwm and compare channel with apb register slave
// assumes one 125 MHz clock; timer ticks and faults synchronous
`timescale 1ns/1ps
module cpd_top
    import cpd_pkg::*;
#(
    parameter int CHANNEL = 1
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpuIdle,
    input wire logic [4:0] timerTick,
    input wire logic faultInputA,
    input wire logic faultInputB,
    input wire logic [2:0] cmpFault,
    output logic compareOutputPin,
    output logic [1:0] fallPhase
);
`include "cpd_defs.svh"

    if (CHANNEL < 1 || CHANNEL > 5) begin : g_bad_channel
        $error("CHANNEL must be 1 to 5");
    end

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    cpd_ctrl1_t ctrl1, next_ctrl1;
    cpd_ctrl2_t ctrl2, next_ctrl2;
    logic [15:0] priReg, next_priReg, secReg, next_secReg;
    logic [15:0] perReg, next_perReg, counter, next_counter;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, hit, wr;

    // no wait state: decode in setup, answer in the first access cycle
    always_comb begin
        hit = 1'b1;
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            `CPD_OFF_CTRL1: next_prdata[15:0] = ctrl1;
            `CPD_OFF_CTRL2: next_prdata[15:0] = ctrl2;
            `CPD_OFF_PRI: next_prdata[15:0] = priReg;
            `CPD_OFF_SEC: next_prdata[15:0] = secReg;
            `CPD_OFF_PER: next_prdata[15:0] = perReg;
            `CPD_OFF_CNT: next_prdata[15:0] = counter;
            default: hit = 1'b0;
        endcase
        next_pready = psel & ~penable;
        next_pslverr = psel & ~penable & ~hit;
        if (!(psel & ~penable)) begin
            next_prdata = 32'h0000_0000;
        end
        wr = psel & penable & pready & pwrite & ~pslverr;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ----------------------------------------
    // time base, buffers and output
    // ----------------------------------------
    logic [15:0] bufPri, next_bufPri, bufSec, next_bufSec;
    logic [1:0] bufDcb, next_bufDcb, next_fallPhase;
    logic faultHold, next_faultHold, pendFall, next_pendFall;
    logic next_pin, tick, run, pwm, center, edgeMode, boundary;
    logic matchPri, matchSec, fallReq, cmpSel, faultNow;
    logic [15:0] limit;

    always_comb begin
        next_ctrl1 = ctrl1;
        next_ctrl2 = ctrl2;
        next_priReg = priReg;
        next_secReg = secReg;
        next_perReg = perReg;
        center = ctrl1.channelMode == `CPD_MODE_CENTER;
        edgeMode = ctrl1.channelMode == `CPD_MODE_EDGE;
        pwm = center | edgeMode;
        cmpSel = cmpFault[(CHANNEL - 1) / 2];
        faultNow = (ctrl1.compFaultEnable & cmpSel)
            | (ctrl1.faultBEnable & faultInputB)
            | (ctrl1.faultAEnable & faultInputA);
        // reserved time base codes give no ticks
        tick = ~(ctrl1.idleStop & cpuIdle);
        if (ctrl1.timeBaseSel != `CPD_TSEL_SYS) begin
            tick = tick & (ctrl1.timeBaseSel <= `CPD_TSEL_LAST_TMR)
                & timerTick[ctrl1.timeBaseSel];
        end
        run = (ctrl1.channelMode != `CPD_MODE_OFF)
            & ~(ctrl2.trigEnable & ~ctrl2.trigger_status_bit);
        limit = center ? perReg : (edgeMode ? bufSec : 16'hffff);
        boundary = tick & run & (counter == limit);
        matchPri = tick & run & (counter == bufPri);
        matchSec = tick & run & (counter == bufSec);
        // counter: free wrap, or restart after the period value in center mode or the secondary buffer in edge mode
        next_counter = counter;
        if (!run) begin
            next_counter = 16'h0000;
        end else if (tick) begin
            next_counter = (boundary & pwm) ? 16'h0000
                : counter + 16'h0001;
        end
        // new duty and delay at a period end in pwm modes, every cycle otherwise
        next_bufPri = bufPri;
        next_bufSec = bufSec;
        next_bufDcb = bufDcb;
        if (!pwm || boundary) begin
            next_bufPri = priReg;
            next_bufSec = secReg;
            next_bufDcb = ctrl2.subcycleDelay;
        end
        // hardware clear of trigger status; a software write wins
        if (ctrl1.trigClearMode && ctrl2.trigger_status_bit
                && counter == bufSec) begin
            next_ctrl2.trigger_status_bit = 1'b0;
        end
        // flags drop at a period end once their source is gone
        if (boundary) begin
            next_ctrl1.compFaultFlag = 1'b0;
            next_ctrl1.faultBFlag = 1'b0;
            next_ctrl1.faultAFlag = 1'b0;
        end
        if (center) begin
            next_ctrl1.compFaultFlag = next_ctrl1.compFaultFlag
                | (ctrl1.compFaultEnable & cmpSel);
            next_ctrl1.faultBFlag = next_ctrl1.faultBFlag
                | (ctrl1.faultBEnable & faultInputB);
            next_ctrl1.faultAFlag = next_ctrl1.faultAFlag
                | (ctrl1.faultAEnable & faultInputA);
        end
        next_faultHold = pwm & (faultNow | (faultHold & ~boundary));
        // software writes; flags are not writable
        if (wr && paddr == `CPD_OFF_CTRL1) begin
            next_ctrl1 = cpd_ctrl1_t'(pwdata[15:0]);
            next_ctrl1.unused = 2'b00;
            next_ctrl1.compFaultFlag = ctrl1.compFaultFlag
                | (center & ctrl1.compFaultEnable & cmpSel);
            next_ctrl1.faultBFlag = ctrl1.faultBFlag
                | (center & ctrl1.faultBEnable & faultInputB);
            next_ctrl1.faultAFlag = ctrl1.faultAFlag
                | (center & ctrl1.faultAEnable & faultInputA);
        end
        if (wr && paddr == `CPD_OFF_CTRL2) begin
            next_ctrl2 = cpd_ctrl2_t'(pwdata[15:0]);
            next_ctrl2.unusedA = 1'b0;
            next_ctrl2.unusedB = 3'h0;
            next_ctrl2.unusedC = 1'b0;
            next_ctrl2.unusedD = 6'h00;
        end
        if (wr && paddr == `CPD_OFF_PRI) next_priReg = pwdata[15:0];
        if (wr && paddr == `CPD_OFF_SEC) next_secReg = pwdata[15:0];
        if (wr && paddr == `CPD_OFF_PER) next_perReg = pwdata[15:0];
        // output edges per mode
        next_pin = pendFall ? 1'b0 : compareOutputPin;
        next_pendFall = 1'b0;
        next_fallPhase = 2'b00;
        fallReq = 1'b0;
        unique case (ctrl1.channelMode)
            `CPD_MODE_OFF: next_pin = 1'b0;
            `CPD_MODE_SET_HI: if (matchPri) next_pin = 1'b1;
            `CPD_MODE_SET_LO: if (matchPri) next_pin = 1'b0;
            `CPD_MODE_TOGGLE: if (matchPri) next_pin = ~compareOutputPin;
            `CPD_MODE_EDGE: begin
                if (boundary) next_pin = 1'b1;
                else fallReq = matchPri;
            end
            default: begin
                if (matchPri) next_pin = 1'b1;
                fallReq = matchSec;
            end
        endcase
        // fine delay: hold high one cycle, pad trims by quarters
        if (fallReq) begin
            if (bufDcb != 2'b00
                    && ctrl1.channelMode != `CPD_MODE_SET_HI) begin
                next_pin = 1'b1;
                next_pendFall = 1'b1;
                next_fallPhase = bufDcb;
            end else begin
                next_pin = 1'b0;
            end
        end
        // boundary duty cases override the edges
        if (edgeMode) begin
            if (bufPri == 16'h0000 && bufSec == 16'h0000) begin
                next_pin = 1'b0;
                next_pendFall = 1'b0;
            end else if (bufSec > bufPri) begin
                next_pin = 1'b1;
                next_pendFall = 1'b0;
            end
        end
        if (center) begin
            if (bufPri == 16'h0000 && bufSec == 16'h0000
                    && perReg == 16'h0000) begin
                next_pin = 1'b0;
                next_pendFall = 1'b0;
            end else if (bufSec > perReg) begin
                next_pin = 1'b1;
                next_pendFall = 1'b0;
            end
        end
        if (next_faultHold) begin
            next_pin = ctrl2.faultLevel;
            next_pendFall = 1'b0;
            next_fallPhase = 2'b00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl1 <= `CPD_RST_CTRL;
            ctrl2 <= `CPD_RST_CTRL;
            priReg <= `CPD_RST_WORD;
            secReg <= `CPD_RST_WORD;
            perReg <= `CPD_RST_WORD;
            counter <= `CPD_RST_WORD;
            bufPri <= `CPD_RST_WORD;
            bufSec <= `CPD_RST_WORD;
            bufDcb <= 2'b00;
            faultHold <= 1'b0;
            pendFall <= 1'b0;
            compareOutputPin <= 1'b0;
            fallPhase <= 2'b00;
        end else begin
            ctrl1 <= next_ctrl1;
            ctrl2 <= next_ctrl2;
            priReg <= next_priReg;
            secReg <= next_secReg;
            perReg <= next_perReg;
            counter <= next_counter;
            bufPri <= next_bufPri;
            bufSec <= next_bufSec;
            bufDcb <= next_bufDcb;
            faultHold <= next_faultHold;
            pendFall <= next_pendFall;
            compareOutputPin <= next_pin;
            fallPhase <= next_fallPhase;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic quiet;
    assign quiet = ~faultNow & ~faultHold;

    a_bus_wait: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_edge_zero: assert property (
        edgeMode && quiet && bufPri == 16'h0000 && bufSec == 16'h0000
        |=> !compareOutputPin) else $error("zero duty not low");
    a_edge_full: assert property (
        edgeMode && quiet && bufSec > bufPri |=> compareOutputPin)
        else $error("full duty not high");
    a_center_zero: assert property (
        center && quiet && bufPri == 16'h0000 && bufSec == 16'h0000
        && perReg == 16'h0000 |=> !compareOutputPin)
        else $error("center zero not low");
    a_center_full: assert property (
        center && quiet && bufSec > perReg |=> compareOutputPin)
        else $error("center full not high");
    a_idle_halt: assert property (
        ctrl1.idleStop && cpuIdle && run && !wr |=> $stable(counter))
        else $error("counter moved in idle");
    a_trig_hold: assert property (
        ctrl2.trigEnable && !ctrl2.trigger_status_bit |=> counter == 16'h0000)
        else $error("counter not held");
    a_trig_clear: assert property (
        ctrl1.trigClearMode && ctrl2.trigger_status_bit && counter == bufSec
        && !wr |=> !ctrl2.trigger_status_bit) else $error("trigger not cleared");
    a_fault_pin: assert property (
        pwm && faultNow && !wr |=> compareOutputPin == ctrl2.faultLevel)
        else $error("fault not driven");
    a_fault_flag: assert property (
        center && ctrl1.faultAEnable && faultInputA && !wr
        |=> ctrl1.faultAFlag) else $error("flag a not set");
    a_sub_fall: assert property (
        pendFall && !faultHold ##1 !faultHold |-> !compareOutputPin
        && $past(fallPhase, 1) != 2'b00) else $error("late fall wrong");
    a_dup_fall: assert property (
        pendFall |-> compareOutputPin ##1 !pendFall)
        else $error("fine delay over one clock");
    a_rsv_zero: assert property (
        ctrl1.unused == 2'b00) else $error("reserved bits set");
endmodule : cpd_top
